/* File: shared/pci_pkg.sv */
// package: register map, field layout and carrier types for the pin change interrupt block
package pci_pkg;
	localparam int          PCI_PINS          = 8;
	localparam int          PCI_ADR_W         = 4;
	// byte offsets of the 32-bit registers
	localparam logic [3:0]  PCI_OFF_RISE      = 4'h0;
	localparam logic [3:0]  PCI_OFF_FALL      = 4'h4;
	localparam logic [3:0]  PCI_OFF_FLAGS     = 4'h8;
	localparam logic [3:0]  PCI_OFF_CTRL      = 4'hC;
	// control register fields
	localparam int          PCI_CTRL_IRQ_EN   = 0;
	localparam int          PCI_CTRL_PENDING  = 1;
	localparam logic [7:0]  PCI_RESET_BYTE    = 8'h00;

	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [3:0]  adr;
		logic [31:0] dat;
	} pci_wb_req_type;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} pci_wb_rsp_type;
endpackage

/* File: hw/pci_top.sv */
// module: pin change detection with per-pin edge enables, sticky flags and sleep wake
`timescale 1ns/100ps
//****************************************
// Notes on behaviour
// - a set rise enable bit makes its pin detect rising edges; reset clears all eight.
// - a set fall enable bit makes its pin detect falling edges; reset clears all eight.
// - a flag sets on an enabled rising or falling edge and otherwise holds unless software writes it.
// - flags are set by hardware, read and written by software, writing zero clears, reset clears.
// - an enabled edge in the same cycle as a flag write leaves that flag set whatever was written.
// - in sleep an enabled edge wakes the core when the module interrupt enable is set.
// - an edge seen in sleep is in the flags before the core runs its first instruction.
// - both enables set on a pin detect rising and falling edges alike.
// - with the module enable clear, detection and flags go on but no request is raised.
// - the pending bit is the or of all eight flags.
//****************************************
module pci_top
	import pci_pkg::*;
(
	// clock and reset
	input  wire logic                core_clk_i,
	input  wire logic                rst_b_i,
	// wishbone slave
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [3:0]          wb_adr_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic                     wb_ack_o,
	output logic [31:0]              wb_dat_o,
	// pins and core status
	input  wire logic [7:0]          watched_pin_i,
	input  wire logic                core_sleep_i,
	output logic                     change_irq_pending_o,
	output logic                     change_irq_o,
	output logic                     wake_o
);

	//****************************************
	// pin synchroniser and edge detect
	//****************************************
	logic [7:0]  sync1_q, sync2_q, prev_q;
	logic [7:0]  sync1_d, sync2_d, prev_d;
	logic [7:0]  rise_edge_enable_q, rise_edge_enable_d;
	logic [7:0]  fall_edge_enable_q, fall_edge_enable_d;
	logic [7:0]  pin_change_flags_q, pin_change_flags_d;
	logic        change_irq_enable_q, change_irq_enable_d;
	logic        ack_q, ack_d;
	logic [31:0] rdat_q, rdat_d;
	logic [7:0]  hit;
	logic        acc;
	pci_wb_req_type req;

	assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};
	assign acc = req.cyc && req.stb && !ack_q;

	// the first stage feeds only the second; edges are judged on sync2 against prev
	// a pulse shorter than one clock may be missed: the price of metastability safety
	always_comb
	begin
		sync1_d = watched_pin_i;
		sync2_d = sync1_q;
		prev_d  = sync2_q;
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			sync1_q <= PCI_RESET_BYTE;
			sync2_q <= PCI_RESET_BYTE;
			prev_q  <= PCI_RESET_BYTE;
		end
		else
		begin
			sync1_q <= sync1_d;
			sync2_q <= sync2_d;
			prev_q  <= prev_d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < PCI_PINS; g++)
		begin : g_pin
			assign hit[g] = (rise_edge_enable_q[g] && sync2_q[g] && !prev_q[g])
				|| (fall_edge_enable_q[g] && !sync2_q[g] && prev_q[g]);
		end
	endgenerate

	//****************************************
	// register file
	//****************************************
	function automatic logic wr_to(input pci_wb_req_type r, input logic [3:0] off);
		wr_to = r.we && r.sel[0] && (r.adr == off);
	endfunction

	always_comb
	begin
		rise_edge_enable_d  = rise_edge_enable_q;
		fall_edge_enable_d  = fall_edge_enable_q;
		pin_change_flags_d  = pin_change_flags_q;
		change_irq_enable_d = change_irq_enable_q;
		ack_d  = acc;
		rdat_d = rdat_q;
		if (acc && wr_to(req, PCI_OFF_RISE))
			rise_edge_enable_d = req.dat[7:0];
		if (acc && wr_to(req, PCI_OFF_FALL))
			fall_edge_enable_d = req.dat[7:0];
		if (acc && wr_to(req, PCI_OFF_FLAGS))
			pin_change_flags_d = req.dat[7:0];
		if (acc && wr_to(req, PCI_OFF_CTRL))
			change_irq_enable_d = req.dat[PCI_CTRL_IRQ_EN];
		// set wins over a simultaneous write
		pin_change_flags_d = pin_change_flags_d | hit;
		if (acc && !req.we)
		begin
			rdat_d = 32'h0000_0000;
			case (req.adr)
				PCI_OFF_RISE:  rdat_d[7:0] = rise_edge_enable_q;
				PCI_OFF_FALL:  rdat_d[7:0] = fall_edge_enable_q;
				PCI_OFF_FLAGS: rdat_d[7:0] = pin_change_flags_q;
				PCI_OFF_CTRL:
				begin
					rdat_d[PCI_CTRL_IRQ_EN]  = change_irq_enable_q;
					rdat_d[PCI_CTRL_PENDING] = |pin_change_flags_q;
				end
				default:       rdat_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			rise_edge_enable_q  <= PCI_RESET_BYTE;
			fall_edge_enable_q  <= PCI_RESET_BYTE;
			pin_change_flags_q  <= PCI_RESET_BYTE;
			change_irq_enable_q <= 1'b0;
			ack_q  <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end
		else
		begin
			rise_edge_enable_q  <= rise_edge_enable_d;
			fall_edge_enable_q  <= fall_edge_enable_d;
			pin_change_flags_q  <= pin_change_flags_d;
			change_irq_enable_q <= change_irq_enable_d;
			ack_q  <= ack_d;
			rdat_q <= rdat_d;
		end
	end

	//****************************************
	// outputs
	//****************************************
	pci_wb_rsp_type rsp;
	assign rsp = '{ack: ack_q, dat: rdat_q};
	assign wb_ack_o = rsp.ack;
	assign wb_dat_o = rsp.dat;
	assign change_irq_pending_o = |pin_change_flags_q;
	assign change_irq_o = change_irq_pending_o && change_irq_enable_q;
	// wake follows the flags, so the flag is already stored when the core resumes
	assign wake_o = core_sleep_i && change_irq_o;

	//****************************************
	// assertions
	//****************************************
	sequence s_rise(int i);
		!prev_q[i] && sync2_q[i] && rise_edge_enable_q[i];
	endsequence

	AST_RISE_SETS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		s_rise(0) |=> pin_change_flags_q[0])
		else $error("rising edge did not set flag 0");
	AST_FALL_SETS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(prev_q[7] && !sync2_q[7] && fall_edge_enable_q[7]) |=> pin_change_flags_q[7])
		else $error("falling edge did not set flag 7");
	AST_NO_SPURIOUS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(hit == 8'h00 && !(acc && req.we && req.adr == PCI_OFF_FLAGS))
		|=> pin_change_flags_q == $past(pin_change_flags_q))
		else $error("flags changed without cause");
	AST_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(acc && wr_to(req, PCI_OFF_FLAGS) && hit == 8'h00) |=> pin_change_flags_q == $past(req.dat[7:0]))
		else $error("flag write not stored");
	AST_SET_WINS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(acc && wr_to(req, PCI_OFF_FLAGS) && hit != 8'h00) |=> ((pin_change_flags_q & $past(hit)) == $past(hit)))
		else $error("edge lost during flag write");
	AST_WAKE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(core_sleep_i && change_irq_enable_q && hit != 8'h00) |=> (wake_o || !core_sleep_i))
		else $error("no wake on edge in sleep");
	AST_MASKED: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!change_irq_enable_q |-> !change_irq_o)
		else $error("request raised while disabled");
	AST_PENDING: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(hit != 8'h00) |=> change_irq_pending_o)
		else $error("pending not raised after edge");
	AST_ACK_ONE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");

	//****************************************
	// per-pin assertions
	//****************************************
	sequence s_fall(int i);
		prev_q[i] && !sync2_q[i] && fall_edge_enable_q[i];
	endsequence

	sequence s_flag_write_edge(int i);
		acc && wr_to(req, PCI_OFF_FLAGS) && hit[i];
	endsequence

	sequence s_quiet_pin(int i);
		!hit[i] && !(acc && wr_to(req, PCI_OFF_FLAGS));
	endsequence

	// every pin is watched, not only the ones the bench happens to toggle
	generate
		for (g = 0; g < PCI_PINS; g++)
		begin : g_pin_chk
			AST_PIN_RISE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
				s_rise(g) |=> pin_change_flags_q[g])
				else $error("rising edge did not set its flag");
			AST_PIN_FALL: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
				s_fall(g) |=> pin_change_flags_q[g])
				else $error("falling edge did not set its flag");
			AST_PIN_BOTH: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
				(rise_edge_enable_q[g] && fall_edge_enable_q[g] && (sync2_q[g] != prev_q[g]))
				|=> pin_change_flags_q[g])
				else $error("edge missed with both enables set");
			AST_PIN_QUIET: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
				s_quiet_pin(g) |=> (pin_change_flags_q[g] == $past(pin_change_flags_q[g])))
				else $error("flag moved without edge or write");
			AST_PIN_SET_WINS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
				s_flag_write_edge(g) |=> pin_change_flags_q[g])
				else $error("write overrode a fresh edge");
			AST_PIN_NO_ENABLE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
				(!rise_edge_enable_q[g] && !fall_edge_enable_q[g] && !pin_change_flags_q[g]
				&& !(acc && wr_to(req, PCI_OFF_FLAGS))) |=> !pin_change_flags_q[g])
				else $error("flag set on a disabled pin");
			AST_PIN_CLEAR: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
				(acc && wr_to(req, PCI_OFF_FLAGS) && !req.dat[g] && !hit[g]) |=> !pin_change_flags_q[g])
				else $error("written zero did not clear the flag");
		end
	endgenerate

	//****************************************
	// register and request assertions
	//****************************************
	AST_RISE_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(acc && wr_to(req, PCI_OFF_RISE)) |=> (rise_edge_enable_q == $past(req.dat[7:0])))
		else $error("rise enable write not stored");
	AST_FALL_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(acc && wr_to(req, PCI_OFF_FALL)) |=> (fall_edge_enable_q == $past(req.dat[7:0])))
		else $error("fall enable write not stored");
	AST_RISE_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!(acc && wr_to(req, PCI_OFF_RISE)) |=> (rise_edge_enable_q == $past(rise_edge_enable_q)))
		else $error("rise enable changed without write");
	AST_FALL_HOLD: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!(acc && wr_to(req, PCI_OFF_FALL)) |=> (fall_edge_enable_q == $past(fall_edge_enable_q)))
		else $error("fall enable changed without write");
	AST_CTRL_WRITE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(acc && wr_to(req, PCI_OFF_CTRL)) |=> (change_irq_enable_q == $past(req.dat[PCI_CTRL_IRQ_EN])))
		else $error("module enable write not stored");
	AST_READ_FLAGS: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(acc && !req.we && (req.adr == PCI_OFF_FLAGS))
		|=> (wb_ack_o && (wb_dat_o == {24'h00_0000, $past(pin_change_flags_q)})))
		else $error("flag read returned wrong data");
	AST_READ_PENDING: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(acc && !req.we && (req.adr == PCI_OFF_CTRL))
		|=> (wb_dat_o[PCI_CTRL_PENDING] == $past(change_irq_pending_o)))
		else $error("pending read returned wrong bit");
	AST_ACK_ANSWER: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		acc |=> wb_ack_o)
		else $error("request not acknowledged");
	AST_NO_ACK_IDLE: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!acc |=> !wb_ack_o)
		else $error("ack without request");
	AST_WAKE_ASLEEP: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		!core_sleep_i |-> !wake_o)
		else $error("wake raised while awake");
	AST_IRQ_PENDING: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		change_irq_o |-> change_irq_pending_o)
		else $error("request without pending flag");
	AST_IRQ_ENABLED: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
		(change_irq_enable_q && change_irq_pending_o) |-> change_irq_o)
		else $error("enabled pending flag raised no request");

endmodule // pci_top

/* File: verif/pci_pins.sv */
// partner model: external levels on the eight watched pins
`timescale 1ns/100ps
module pci_pins
(
	// clock and requested levels
	input  wire logic       core_clk_i,
	input  wire logic [7:0] pin_req_i,
	// pins toward the block
	output logic [7:0]      watched_pin_o
);
	// levels move just after an edge, so the block never sees a change on its own sampling edge
	always_ff @(posedge core_clk_i)
		watched_pin_o <= pin_req_i;
endmodule // pci_pins

/* File: verif/tb.sv */
// testbench: register, edge, clear and sleep scenarios for the pin change block
`timescale 1ns/100ps
module tb import pci_pkg::*;;
	logic        core_clk_i = 0, rst_b_i = 0, cyc = 0, stb = 0, we = 0, sleep = 0, ack, pend, irq, wake;
	logic [3:0]  adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, r;
	logic [7:0]  pin_req = 8'h00, pins;
	int          bad_count = 0, n_checks = 0, n;
	always #5 core_clk_i = ~core_clk_i;
	pci_pins u_pins (.core_clk_i(core_clk_i), .pin_req_i(pin_req), .watched_pin_o(pins));
	pci_top uut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_sel_i(4'hF), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_ack_o(ack),
		.wb_dat_o(rdat), .watched_pin_i(pins), .core_sleep_i(sleep),
		.change_irq_pending_o(pend), .change_irq_o(irq), .wake_o(wake));
	//****************************************
	// bus and compare helpers
	//****************************************
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// request is held until ack is sampled high; read data is taken at that same edge
	task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h0, d};
		do @(posedge core_clk_i); while (ack !== 1'b1 && ++n < 50);
		r = rdat;
		if (n >= 50) bad_count++;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge core_clk_i);
	endtask
	task rd(input logic [3:0] a, input logic [7:0] exp, input string nm);
		bus(1'b0, a, 8'h00);
		chk(nm, r, {24'h0, exp});
	endtask
	// pins must hold one cycle to be seen; six leaves room for the flag to land
	task pin(input logic [7:0] v);
		pin_req <= v;
		repeat (6) @(posedge core_clk_i);
	endtask
	task give_verdict;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	//****************************************
	// scenarios
	//****************************************
	task t_reset;
		rd(PCI_OFF_RISE, 8'h00, "rise");
		rd(PCI_OFF_FALL, 8'h00, "fall");
		rd(PCI_OFF_FLAGS, 8'h00, "flags");
		rd(4'h2, 8'h00, "unmapped");
	endtask
	task t_edges;
		bus(1'b1, PCI_OFF_RISE, 8'h81);
		bus(1'b1, PCI_OFF_FALL, 8'h82);
		rd(PCI_OFF_RISE, 8'h81, "rise rw");
		pin(8'h83);
		rd(PCI_OFF_FLAGS, 8'h81, "rise flags");
		chk("pending", pend, 1);
		chk("irq masked", irq, 0);
		pin(8'h00);
		rd(PCI_OFF_FLAGS, 8'h83, "fall flags");
	endtask
	task t_clear;
		bus(1'b0, PCI_OFF_FLAGS, 8'h00);
		bus(1'b1, PCI_OFF_FLAGS, (r[7:0] ^ 8'hFF) & r[7:0]);
		rd(PCI_OFF_FLAGS, 8'h00, "cleared");
		chk("pending low", pend, 0);
		pin(8'h80);
		rd(PCI_OFF_FLAGS, 8'h80, "both rise");
		bus(1'b1, PCI_OFF_FLAGS, 8'h00);
		pin(8'h00);
		rd(PCI_OFF_FLAGS, 8'h80, "both fall");
		bus(1'b1, PCI_OFF_FLAGS, 8'h00);
	endtask
	// the edge reaches the flag at the edge where the clearing write lands
	task t_race;
		pin_req <= 8'h01;
		repeat (3) @(posedge core_clk_i);
		bus(1'b1, PCI_OFF_FLAGS, 8'h00);
		rd(PCI_OFF_FLAGS, 8'h01, "set wins");
		bus(1'b1, PCI_OFF_FLAGS, 8'h00);
	endtask
	task t_sleep;
		bus(1'b1, PCI_OFF_CTRL, 8'h01);
		sleep <= 1'b1;
		pin_req <= 8'h80;
		n = 0;
		do @(posedge core_clk_i); while (wake !== 1'b1 && ++n < 20);
		chk("wake", wake, 1);
		chk("flag at wake", pend, 1);
		chk("irq", irq, 1);
		sleep <= 1'b0;
		@(posedge core_clk_i);
		rd(PCI_OFF_CTRL, 8'h03, "ctrl");
		rd(PCI_OFF_FLAGS, 8'h80, "sleep flag");
		sleep <= 1'b1;
		bus(1'b1, PCI_OFF_CTRL, 8'h00);
		chk("no wake masked", wake, 0);
	endtask
	initial
	begin
		repeat (10) @(posedge core_clk_i);
		rst_b_i <= 1'b1;
		@(posedge core_clk_i);
		t_reset;
		t_edges;
		t_clear;
		t_race;
		t_sleep;
		give_verdict;
	end
	initial
	begin
		repeat (3000) @(posedge core_clk_i);
		bad_count++;
		give_verdict;
	end
endmodule // tb
